// ### hw/sxd_handler.sv
// Exclusive message parser, parameter store and reply generator
`timescale 1ns/1ps
`default_nettype none
module sxd_handler import sxd_pkg::*; #(
    parameter int unsigned SENSE_CYC = SENSE_MS * (CLK_HZ / 1000)
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] rx_byte,
    input  wire logic       rx_valid,
    output logic      [7:0] tx_byte,
    output logic            tx_valid,
    input  wire logic       tx_ready,
    output logic            par_wr_valid,
    output sxd_wr_t         par_wr,
    output sxd_sys_t        sys,
    output logic            ext_mode,
    output logic            tune_valid,
    output logic     [10:0] tune_val,
    output logic            sys_on,
    output logic            all_reset,
    output logic            drum_reset,
    output logic            drum_num,
    output logic            sense_armed,
    output logic            all_off
);
    // Block size at a base address; rx hides blocks that cannot be received
    function automatic logic [13:0] blk_size(input sxd_addr_t a, input logic rx);
        blk_size = '0;
        if (a.lo == BASE_LO) begin
            if (a.hi == SYS_HI && a.mid == SYS_MID) blk_size = SYS_SIZE;
            else if (a.hi == INFO_HI && a.mid == INFO_MID && !rx) blk_size = INFO_SIZE;
            else if (a.hi == EFF_HI && a.mid == EFF_MID) blk_size = EFF_SIZE;
            else if (a.hi == PART_HI && a.mid <= PART_MID_MAX) blk_size = PART_SIZE;
            else if ((a.hi == DRUM_HI0 || a.hi == DRUM_HI1) && a.mid == DRUM_MID) blk_size = DRUM_SIZE;
        end
    endfunction : blk_size

    sxd_pst_t    pst_r;
    logic [7:0]  buf_r [MSG_DEPTH];
    logic [7:0]  pos_r;
    logic [7:0]  sum_r;
    logic [1:0]  cmd_r;
    logic [3:0]  dev_r;
    logic        tmod_r;
    logic [7:0]  cbase_r;
    logic [7:0]  cn_r;
    logic [7:0]  ci_r;
    sxd_addr_t   caddr_r;
    logic [6:0]  sys_r [7];
    logic        tx_run_r;
    logic        tx_bulk_r;
    logic        tx_info_r;
    logic [3:0]  tx_dev_r;
    sxd_addr_t   tx_addr_r;
    logic [4:0]  tx_n_r;
    logic [4:0]  tx_idx_r;
    logic [6:0]  tx_sum_r;
    logic [23:0] sense_cnt_r;

    // Realtime bytes pass through the parser untouched
    logic is_rt;
    logic fin;
    assign is_rt = rx_byte >= RT_MIN;
    assign fin   = pst_r == P_BODY && rx_valid && rx_byte == SX_END;

    // End-of-message decisions
    sxd_addr_t   a_bulk;
    sxd_addr_t   a_par;
    logic [13:0] cnt;
    logic        bulk_ok;
    logic        pchg_ok;
    logic        tune_ok;
    logic        preq_ok;
    logic        dreq_ok;
    logic        req_go;
    assign a_bulk  = '{buf_r[2][6:0], buf_r[3][6:0], buf_r[4][6:0]};
    assign a_par   = '{buf_r[0][6:0], buf_r[1][6:0], buf_r[2][6:0]};
    assign cnt     = {buf_r[0][6:0], buf_r[1][6:0]};
    assign bulk_ok = fin && !tmod_r && cmd_r == CMD_DUMP && {6'h00, pos_r} == cnt + BULK_OVH
                     && cnt != '0 && cnt == blk_size(a_bulk, 1'b1)
                     && sum_r[6:0] == '0;
    assign pchg_ok = fin && !tmod_r && cmd_r == CMD_PCHG && pos_r > P_DATA;
    assign tune_ok = fin && tmod_r && pos_r == T_LEN && a_par == sxd_addr_t'{TUNE_HI, BASE_LO, BASE_LO};
    assign preq_ok = fin && !tmod_r && cmd_r == CMD_PREQ && pos_r == REQ_LEN && a_par.hi == SYS_HI
                     && a_par.mid == SYS_MID && a_par.lo < SYS_SIZE[6:0] && a_par.lo != SYS_UNUSED;
    assign dreq_ok = fin && !tmod_r && cmd_r == CMD_DREQ && pos_r == REQ_LEN
                     && blk_size(a_par, 1'b0) != '0 && (a_par.hi == SYS_HI || a_par.hi == INFO_HI);
    assign req_go  = (preq_ok || dreq_ok) && !tx_run_r;

    // Message parser; a new start byte resynchronises in every state except P_COMMIT, which ignores received bytes
    always_ff @(posedge clk) begin
        if (reset) begin
            pst_r <= P_IDLE;
            pos_r <= '0;
            sum_r <= '0;
            cmd_r <= '0;
            dev_r <= '0;
            tmod_r <= 1'b0;
            ci_r <= '0;
            cn_r <= '0;
            cbase_r <= '0;
            caddr_r <= '0;
        end else if (pst_r == P_COMMIT) begin
            ci_r <= ci_r + 8'h01;
            if (ci_r == cn_r - 8'h01) pst_r <= P_IDLE;
        end else if (rx_valid && !is_rt) begin
            if (rx_byte == SX_START) begin
                pst_r <= P_MAKER;
                pos_r <= '0;
                sum_r <= '0;
            end else if (rx_byte[7] && (rx_byte != SX_END || pst_r != P_BODY)) begin
                pst_r <= P_IDLE;
            end else begin
                unique case (pst_r)
                    P_MAKER: pst_r <= rx_byte == MAKER_ID ? P_CMD : P_SKIP;
                    P_CMD: begin
                        cmd_r <= rx_byte[5:4];
                        dev_r <= rx_byte[3:0];
                        pst_r <= rx_byte[6] ? P_SKIP : P_MODEL;
                    end
                    P_MODEL: begin
                        tmod_r <= rx_byte == TUNE_MODEL;
                        pst_r <= (rx_byte == MODEL_ID || (rx_byte == TUNE_MODEL && cmd_r == CMD_PCHG))
                                 ? P_BODY : P_SKIP;
                    end
                    P_BODY: begin
                        if (rx_byte == SX_END) begin
                            ci_r <= '0;
                            pst_r <= (bulk_ok || pchg_ok) ? P_COMMIT : P_IDLE;
                            cbase_r <= bulk_ok ? B_DATA : P_DATA;
                            cn_r <= bulk_ok ? cnt[7:0] : pos_r - P_DATA;
                            caddr_r <= bulk_ok ? a_bulk : a_par;
                        end else if (pos_r == MSG_DEPTH) begin
                            pst_r <= P_SKIP;                                                // Oversize frame
                        end else begin
                            pos_r <= pos_r + 8'h01;
                            sum_r <= sum_r + rx_byte;
                        end
                    end
                    P_SKIP, P_IDLE, P_COMMIT: ;
                endcase
            end
        end
    end

    // Body store kept apart so the array has no reset
    always_ff @(posedge clk) begin
        if (pst_r == P_BODY && rx_valid && !rx_byte[7] && pos_r != MSG_DEPTH) buf_r[pos_r] <= rx_byte;
    end

    // Writes replay only after the whole frame checked out
    sxd_wr_t wr_c;
    logic    wr_v;
    logic    sys_hit;
    assign wr_v    = pst_r == P_COMMIT;
    assign wr_c    = '{'{caddr_r.hi, caddr_r.mid, caddr_r.lo + ci_r[6:0]}, buf_r[cbase_r + ci_r][6:0]};
    assign sys_hit = wr_v && wr_c.addr.hi == SYS_HI && wr_c.addr.mid == SYS_MID;

    // Outgoing write port, registered
    always_ff @(posedge clk) begin
        if (reset) begin
            par_wr_valid <= 1'b0;
            par_wr <= '0;
        end else begin
            par_wr_valid <= wr_v;
            par_wr <= wr_c;
        end
    end

    // System block store; out-of-range transpose is dropped
    always_ff @(posedge clk) begin
        if (reset || (sys_hit && wr_c.addr.lo == SYS_ALL_RST)) begin
            for (int i = 0; i < 7; i++) begin
                sys_r[i] <= SYS_DEF[i];
            end
        end else if (sys_hit) begin
            if (wr_c.addr.lo <= SYS_TUNE_LAST) sys_r[wr_c.addr.lo[2:0]] <= {3'h0, wr_c.data[3:0]};
            if (wr_c.addr.lo == SYS_VOL) sys_r[SYS_VOL[2:0]] <= wr_c.data;
            if (wr_c.addr.lo == SYS_TRN && wr_c.data >= TRN_MIN && wr_c.data <= TRN_MAX)
                sys_r[SYS_TRN[2:0]] <= wr_c.data;
        end
    end
    assign sys = '{{sys_r[0][3:0], sys_r[1][3:0], sys_r[2][3:0], sys_r[3][3:0]}, sys_r[4], sys_r[6]};

    // Command pulses and the mode flag
    always_ff @(posedge clk) begin
        if (reset) begin
            ext_mode <= 1'b0;
            sys_on <= 1'b0;
            all_reset <= 1'b0;
            drum_reset <= 1'b0;
            drum_num <= 1'b0;
            tune_valid <= 1'b0;
            tune_val <= '0;
        end else begin
            sys_on <= sys_hit && wr_c.addr.lo == SYS_ON && wr_c.data == SYS_ON_VAL;
            if (sys_hit && wr_c.addr.lo == SYS_ON && wr_c.data == SYS_ON_VAL) ext_mode <= 1'b1;
            all_reset <= sys_hit && wr_c.addr.lo == SYS_ALL_RST;
            drum_reset <= sys_hit && wr_c.addr.lo == SYS_DRUM_RST && wr_c.data <= DRUM_NUM_MAX;
            if (sys_hit && wr_c.addr.lo == SYS_DRUM_RST) drum_num <= wr_c.data[0];
            tune_valid <= tune_ok;
            if (tune_ok) tune_val <= {buf_r[3][3:0], buf_r[4][6:0]};
        end
    end

    // Reply byte selection
    logic [4:0] dstart;
    logic [4:0] doff;
    logic [6:0] rd;
    logic [7:0] nxt;
    logic       last;
    logic       load;
    always_comb begin
        dstart = tx_bulk_r ? TX_BULK_DATA : TX_PAR_DATA;
        doff = tx_idx_r - dstart;
        rd = tx_info_r ? INFO_DATA[tx_addr_r.lo[3:0] + doff[3:0]] : sys_r[tx_addr_r.lo[2:0] + doff[2:0]];
        last = tx_idx_r == dstart + tx_n_r + {4'h0, tx_bulk_r};
        unique case (tx_idx_r)
            5'h00: nxt = SX_START;
            5'h01: nxt = MAKER_ID;
            5'h02: nxt = {2'h0, tx_bulk_r ? CMD_DUMP : CMD_PCHG, tx_dev_r};
            5'h03: nxt = MODEL_ID;
            default: begin
                if (tx_idx_r >= dstart + tx_n_r) nxt = last ? SX_END : {1'b0, 7'(-tx_sum_r)};
                else if (tx_idx_r >= dstart) nxt = {1'b0, rd};
                else if (tx_idx_r == dstart - TX_ADDR_LEN) nxt = {1'b0, tx_addr_r.hi};
                else if (tx_idx_r == dstart - 5'h02) nxt = {1'b0, tx_addr_r.mid};
                else if (tx_idx_r == dstart - 5'h01) nxt = {1'b0, tx_addr_r.lo};
                else if (tx_idx_r == TX_HDR_LEN) nxt = 8'h00;       // Count high, blocks are small
                else nxt = {3'h0, tx_n_r};
            end
        endcase
    end
    assign load = tx_run_r && (!tx_valid || tx_ready);

    // Reply sequencer; requests arriving while busy are dropped
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_run_r <= 1'b0;
            tx_valid <= 1'b0;
            tx_byte <= '0;
            tx_idx_r <= '0;
            tx_sum_r <= '0;
            tx_bulk_r <= 1'b0;
            tx_info_r <= 1'b0;
            tx_dev_r <= '0;
            tx_addr_r <= '0;
            tx_n_r <= '0;
        end else begin
            if (tx_valid && tx_ready) tx_valid <= 1'b0;
            if (load) begin
                tx_byte <= nxt;
                tx_valid <= 1'b1;
                tx_idx_r <= tx_idx_r + 5'h01;
                if (tx_idx_r >= TX_HDR_LEN && tx_idx_r < dstart + tx_n_r) tx_sum_r <= tx_sum_r + nxt[6:0];
                if (last) tx_run_r <= 1'b0;
            end else if (req_go) begin
                tx_run_r <= 1'b1;
                tx_idx_r <= '0;
                tx_sum_r <= '0;
                tx_bulk_r <= dreq_ok;
                tx_info_r <= a_par.hi == INFO_HI;
                tx_dev_r <= dev_r;
                tx_addr_r <= a_par;
                tx_n_r <= dreq_ok ? (a_par.hi == INFO_HI ? INFO_SIZE[4:0] : SYS_SIZE[4:0])
                                  : (a_par.lo == SYS_TUNE ? TUNE_LEN : 5'h01);
            end
        end
    end

    // Link monitor; any byte restarts the silence count
    always_ff @(posedge clk) begin
        if (reset) begin
            sense_armed <= 1'b0;
            sense_cnt_r <= '0;
            all_off <= 1'b0;
        end else begin
            all_off <= 1'b0;
            if (rx_valid) begin
                sense_cnt_r <= '0;
                if (rx_byte == ACT_SENSE) sense_armed <= 1'b1;
            end else if (sense_armed) begin
                if (sense_cnt_r == 24'(SENSE_CYC - 1)) begin
                    all_off <= 1'b1;
                    sense_armed <= 1'b0;
                    sense_cnt_r <= '0;
                end else begin
                    sense_cnt_r <= sense_cnt_r + 24'h000001;
                end
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_sense_fire: assert property (sense_armed && !rx_valid && sense_cnt_r == 24'(SENSE_CYC - 1)
        |=> all_off && !sense_armed) else $error("link loss not reported");
    a_sense_arm: assert property (rx_valid && rx_byte == ACT_SENSE |=> sense_armed && !all_off)
        else $error("monitor not armed");
    a_never_sense: assert property (tx_valid |-> tx_byte != ACT_SENSE)
        else $error("active sensing sent");
    a_reply_start: assert property ($rose(tx_valid) |-> tx_byte == SX_START)
        else $error("reply not opened by start byte");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("reply byte changed while stalled");
    a_bad_sum: assert property (fin && cmd_r == CMD_DUMP && sum_r[6:0] != '0 |=> pst_r == P_IDLE)
        else $error("bad checksum dump committed");
    a_info_drop: assert property (fin && cmd_r == CMD_DUMP && a_bulk.hi == INFO_HI |=> !wr_v)
        else $error("information dump written");
    a_maker_skip: assert property (pst_r == P_MAKER && rx_valid && !rx_byte[7] && rx_byte != MAKER_ID
        |=> pst_r == P_SKIP) else $error("foreign maker accepted");
    a_mode_set: assert property (sys_hit && wr_c.addr.lo == SYS_ON && wr_c.data == SYS_ON_VAL
        |=> ##1 ext_mode) else $error("mode not entered");
    a_wr_follow: assert property (wr_v |=> par_wr_valid ##1 (par_wr_valid || !$past(wr_v)))
        else $error("write port lost a write");
    c_bulk: cover property (bulk_ok);
    c_dump_reply: cover property (dreq_ok && !tx_run_r ##[1:40] tx_valid && tx_byte == SX_END);
    c_tune: cover property (tune_valid);
    c_link_loss: cover property (all_off);
endmodule : sxd_handler
`default_nettype wire

// ### hw/sxd_pkg.sv
// Constants and types for the exclusive message handler
package sxd_pkg;
    // Link framing bytes
    localparam logic [7:0] SX_START   = 8'hf0;
    localparam logic [7:0] SX_END     = 8'hf7;
    localparam logic [7:0] ACT_SENSE  = 8'hfe;
    localparam logic [7:0] RT_MIN     = 8'hf8;
    // Identity bytes, arbitrary values
    localparam logic [7:0] MAKER_ID   = 8'h11;
    localparam logic [7:0] MODEL_ID   = 8'h22;
    localparam logic [7:0] TUNE_MODEL = 8'h33;
    // Command nibbles
    localparam logic [1:0] CMD_DUMP = 2'h0;
    localparam logic [1:0] CMD_PCHG = 2'h1;
    localparam logic [1:0] CMD_DREQ = 2'h2;
    localparam logic [1:0] CMD_PREQ = 2'h3;
    // Block bases
    localparam logic [6:0] SYS_HI = 7'h00;
    localparam logic [6:0] SYS_MID = 7'h00;
    localparam logic [6:0] INFO_HI = 7'h01;
    localparam logic [6:0] INFO_MID = 7'h00;
    localparam logic [6:0] EFF_HI = 7'h02;
    localparam logic [6:0] EFF_MID = 7'h01;
    localparam logic [6:0] PART_HI = 7'h08;
    localparam logic [6:0] PART_MID_MAX = 7'h0f;
    localparam logic [6:0] DRUM_HI0 = 7'h30;
    localparam logic [6:0] DRUM_HI1 = 7'h31;
    localparam logic [6:0] DRUM_MID = 7'h0d;
    localparam logic [6:0] TUNE_HI = 7'h30;
    localparam logic [6:0] BASE_LO = 7'h00;
    // System block offsets and limits
    localparam logic [6:0] SYS_TUNE = 7'h00;
    localparam logic [6:0] SYS_TUNE_LAST = 7'h03;
    localparam logic [6:0] SYS_VOL = 7'h04;
    localparam logic [6:0] SYS_UNUSED = 7'h05;
    localparam logic [6:0] SYS_TRN = 7'h06;
    localparam logic [6:0] SYS_DRUM_RST = 7'h7d;
    localparam logic [6:0] SYS_ON = 7'h7e;
    localparam logic [6:0] SYS_ALL_RST = 7'h7f;
    localparam logic [6:0] TRN_MIN = 7'h28;
    localparam logic [6:0] TRN_MAX = 7'h58;
    localparam logic [6:0] SYS_ON_VAL = 7'h00;
    localparam logic [6:0] DRUM_NUM_MAX = 7'h01;
    localparam logic [13:0] SYS_SIZE = 14'h0007;
    localparam logic [13:0] INFO_SIZE = 14'h0010;
    localparam logic [13:0] EFF_SIZE = 14'h0010;
    localparam logic [13:0] PART_SIZE = 14'h0010;
    localparam logic [13:0] DRUM_SIZE = 14'h0010;
    localparam logic [4:0] TUNE_LEN = 5'h04;
    localparam logic [6:0] SYS_DEF [7] = '{7'h00, 7'h04, 7'h00, 7'h00, 7'h7f, 7'h00, 7'h40};
    // Name bytes and levels, arbitrary values
    localparam logic [6:0] INFO_DATA [16] = '{7'h54, 7'h4f, 7'h4e, 7'h45, 7'h20, 7'h47, 7'h45, 7'h4e,
                                              7'h20, 7'h20, 7'h20, 7'h20, 7'h20, 7'h20, 7'h01, 7'h01};
    // Receive buffer layout
    localparam logic [7:0] MSG_DEPTH = 8'h8c;
    localparam logic [7:0] B_DATA = 8'h05;
    localparam logic [7:0] P_DATA = 8'h03;
    localparam logic [7:0] REQ_LEN = 8'h03;
    localparam logic [7:0] T_LEN = 8'h06;
    localparam logic [13:0] BULK_OVH = 14'h0006;
    // Reply layout
    localparam logic [4:0] TX_HDR_LEN = 5'h04;
    localparam logic [4:0] TX_BULK_DATA = 5'h09;
    localparam logic [4:0] TX_PAR_DATA = 5'h07;
    localparam logic [4:0] TX_ADDR_LEN = 5'h03;
    // Timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned SENSE_MS = 300;

    typedef struct packed {
        logic [6:0] hi;
        logic [6:0] mid;
        logic [6:0] lo;
    } sxd_addr_t;
    typedef struct packed {
        sxd_addr_t  addr;
        logic [6:0] data;
    } sxd_wr_t;
    typedef struct packed {
        logic [15:0] tune;
        logic [6:0]  volume;
        logic [6:0]  transpose;
    } sxd_sys_t;
    typedef enum logic [6:0] {
        P_IDLE = 7'b0000001, P_MAKER = 7'b0000010, P_CMD = 7'b0000100, P_MODEL = 7'b0001000,
        P_BODY = 7'b0010000, P_SKIP = 7'b0100000, P_COMMIT = 7'b1000000
    } sxd_pst_t;
endpackage : sxd_pkg

// ### tb/sxd_seq_model.sv
// Sequencer model that takes reply bytes from the handler
`timescale 1ns/1ps
`default_nettype none
module sxd_seq_model import sxd_pkg::*; (
    input  wire logic       clk,
    input  wire logic       slow,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_valid,
    output logic            tx_ready
);
    logic [7:0] got [$];
    logic       fe_seen = 1'b0;
    // Alternate stalls when slow, so a byte must hold across them
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_byte);
            if (tx_byte == ACT_SENSE) fe_seen <= 1'b1;
        end
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
endmodule : sxd_seq_model
`default_nettype wire

// ### tb/sxd_handler_test.sv
// Self-checking bench for the exclusive message handler
`timescale 1ns/1ps
`default_nettype none
module sxd_handler_test;
    import sxd_pkg::*;
    logic clk = 1'b0, reset = 1'b1, rx_valid = 1'b0, slow = 1'b0, tx_ready, tx_valid, par_wr_valid;
    logic ext_mode, tune_valid, sys_on, all_reset, drum_reset, drum_num, sense_armed, all_off;
    logic [7:0]  rx_byte = 8'h00, tx_byte;
    logic [10:0] tune_val, tv_r = 11'h000;
    logic [7:0]  q [$];
    sxd_wr_t  par_wr, wr_last;
    sxd_sys_t sys;
    int n_mismatch = 0, cmp_count = 0, n_wr = 0, n_on = 0, n_rst = 0, n_drum = 0, k;
    always #10 clk = ~clk;
    // Pulses are caught here so the tests can read them later
    always @(posedge clk) begin
        if (par_wr_valid) n_wr++;
        if (par_wr_valid) wr_last <= par_wr;
        if (tune_valid) tv_r <= tune_val;
        if (sys_on) n_on++;
        if (all_reset) n_rst++;
        if (drum_reset) n_drum++;
    end
    sxd_handler #(.SENSE_CYC(50)) dut (.clk(clk), .reset(reset), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .par_wr_valid(par_wr_valid),
        .par_wr(par_wr), .sys(sys), .ext_mode(ext_mode), .tune_valid(tune_valid), .tune_val(tune_val),
        .sys_on(sys_on), .all_reset(all_reset), .drum_reset(drum_reset), .drum_num(drum_num),
        .sense_armed(sense_armed), .all_off(all_off));
    sxd_seq_model seq (.clk(clk), .slow(slow), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One byte per cycle, then idle 30 cycles, long enough for the commits these tests cause
    task automatic send(input logic [7:0] b [$]);
        foreach (b[i]) begin
            rx_byte <= b[i];
            rx_valid <= 1'b1;
            @(posedge clk);
        end
        rx_valid <= 1'b0;
        repeat (30) @(posedge clk);
    endtask : send
    task automatic expect_reply(input logic [7:0] e [$]);
        int w;
        w = 0;
        while (seq.got.size() < e.size() && w < 300) begin
            @(posedge clk);
            w++;
        end
        chk(seq.got.size(), e.size());
        foreach (e[i]) if (i < seq.got.size()) chk(seq.got[i], e[i]);
        seq.got.delete();
        $display("reply test done");
    endtask : expect_reply
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Whole run needs well under this many cycles
    initial begin
        repeat (6000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        send('{8'hf0, 8'h11, 8'h15, 8'h22, 8'h00, 8'h00, 8'h04, 8'h55, 8'hf7});
        chk(sys.volume, 8'h55);
        chk(n_wr, 1);
        send('{8'hf0, 8'h11, 8'h35, 8'h22, 8'h00, 8'h00, 8'h04, 8'hf7});
        expect_reply('{8'hf0, 8'h11, 8'h15, 8'h22, 8'h00, 8'h00, 8'h04, 8'h55, 8'hf7});
        slow <= 1'b1;
        send('{8'hf0, 8'h11, 8'h25, 8'h22, 8'h00, 8'h00, 8'h00, 8'hf7});
        expect_reply('{8'hf0, 8'h11, 8'h05, 8'h22, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04,
                       8'h00, 8'h00, 8'h55, 8'h00, 8'h40, 8'h60, 8'hf7});
        send('{8'hf0, 8'h11, 8'h25, 8'h22, 8'h00, 8'h00, 8'h01, 8'hf7});
        repeat (60) @(posedge clk);
        chk(seq.got.size(), 0);
        // Information block goes out on request with its fixed contents
        send('{8'hf0, 8'h11, 8'h2a, 8'h22, 8'h01, 8'h00, 8'h00, 8'hf7});
        q = '{8'hf0, 8'h11, 8'h0a, 8'h22, 8'h00, 8'h10, 8'h01, 8'h00, 8'h00};
        k = 8'h11;
        foreach (INFO_DATA[i]) begin
            q.push_back({1'b0, INFO_DATA[i]});
            k += INFO_DATA[i];
        end
        q.push_back({1'b0, 7'(-k)});
        q.push_back(8'hf7);
        expect_reply(q);
        send('{8'hf0, 8'h11, 8'h05, 8'h22, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00,
               8'h00, 8'h10, 8'h00, 8'h30, 8'h35, 8'hf7});
        chk(sys.volume, 8'h10);
        chk(sys.transpose, 8'h30);
        send('{8'hf0, 8'h11, 8'h05, 8'h22, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00,
               8'h00, 8'h20, 8'h00, 8'h30, 8'h35, 8'hf7});
        chk(sys.volume, 8'h10);
        send('{8'hf0, 8'h12, 8'h15, 8'h22, 8'h00, 8'h00, 8'h04, 8'h44, 8'hf7});
        chk(sys.volume, 8'h10);
        // Information dump with a good checksum must still be dropped
        q = '{8'hf0, 8'h11, 8'h05, 8'h22, 8'h00, 8'h10, 8'h01, 8'h00, 8'h00};
        repeat (16) q.push_back(8'h41);
        q.push_back(8'h5f);
        q.push_back(8'hf7);
        k = n_wr;
        send(q);
        chk(n_wr, k);
        send('{8'hf0, 8'h11, 8'h15, 8'h33, 8'h30, 8'h00, 8'h00, 8'h05, 8'h2a, 8'h00, 8'hf7});
        chk(tv_r, 11'h2aa);
        send('{8'hf0, 8'h11, 8'h15, 8'h22, 8'h00, 8'h00, 8'h7e, 8'h00, 8'hf7});
        chk(ext_mode, 1'b1);
        chk(n_on, 1);
        // Settle time after system on, scaled down for simulation
        repeat (50) @(posedge clk);
        send('{8'hf0, 8'h11, 8'h15, 8'h22, 8'h00, 8'h00, 8'h06, 8'h59, 8'hf7});
        chk(sys.transpose, 8'h30);
        // Global tuning through the system block, four nibbles in one change
        send('{8'hf0, 8'h11, 8'h15, 8'h22, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hf7});
        chk(sys.tune, 16'h1234);
        chk(wr_last, {7'h00, 7'h00, 7'h03, 7'h04});
        send('{8'hf0, 8'h11, 8'h15, 8'h22, 8'h00, 8'h00, 8'h7d, 8'h01, 8'hf7});
        chk(n_drum, 1);
        chk(drum_num, 1'b1);
        send('{8'hf0, 8'h11, 8'h15, 8'h22, 8'h00, 8'h00, 8'h7f, 8'h00, 8'hf7});
        chk(n_rst, 1);
        chk(sys.volume, 8'h7f);
        $display("write test done");
        // Armed monitor must time out near the shortened period
        rx_byte <= 8'hfe;
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
        @(posedge clk);
        chk(sense_armed, 1'b1);
        k = 0;
        while (all_off !== 1'b1 && k < 100) begin
            @(posedge clk);
            k++;
        end
        chk(k, 50);
        @(posedge clk);
        chk(sense_armed, 1'b0);
        chk(seq.fe_seen, 1'b0);
        $display("monitor test done");
        tally_and_finish();
    end
endmodule : sxd_handler_test
`default_nettype wire
